// [design/trcrec_ctrl.sv]
// Trace recorder control: AHB-Lite registers, capture, masking, capacity.
// Function
// [RULE1] Each of eight channels has a mask: 0 keeps the word, n keeps bit n-1.
// [RULE2] Input and output status words map their pins onto masks by bit.
// [RULE3] A one-bit activation control starts recording when set to 1.
// [RULE4] All settings are captured only on the activation rising edge.
// [RULE5] Settings changed while active wait for the next 0 then 1.
// [RULE6] The memory share runs 1 to 100 percent and resets to 100.
// [RULE7] Capacity in samples is share over 100 times total trace memory.
`default_nettype none
module trcrec_ctrl
  import trcrec_pkg::*;
#(
  parameter int NCH = 8,
  parameter int DW = 16,
  parameter int TOTAL_MEM = 8192,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [NCH*DW-1:0] smp_data,
  output logic rec_valid,
  input wire logic rec_ready,
  output logic [NCH*DW-1:0] rec_data,
  output logic trace_running,
  output logic trace_done
);
  logic [DW-1:0] mask_q [NCH];
  logic [DW-1:0] mask_d [NCH];
  logic [DW-1:0] sh_q [NCH];
  logic [DW-1:0] sh_d [NCH];
  logic act_q, act_d;
  logic [15:0] share_q, share_d, share_eff;
  logic [31:0] cap_q, cap_d, cnt_q, cnt_d;
  trcrec_state_t st_q, st_d;
  logic wr_q, wr_d, rp_q, rp_d;
  logic [TRC_AW-1:0] a_q, a_d;
  logic [31:0] rdata_q, rdata_d;
  logic accept, start, push, fifo_rdy;
  logic [NCH*DW-1:0] push_data;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: writes take no wait state, reads take one.
  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ ||
                  htrans == HTRANS_SEQ);
  assign hreadyout = !rp_q;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign trace_running = (st_q == TRC_RUN);
  assign trace_done = (st_q == TRC_DONE);

  // Clamp the share into its legal range before it sizes the capacity.
  assign share_eff = (share_q < SHARE_MIN) ? SHARE_MIN :
                     (share_q > SHARE_MAX) ? SHARE_MAX : share_q;

  // An activation write of 1 while inactive is the capture edge.
  // [RULE3] [RULE4] activation edge capture
  assign start = wr_q && a_q == OFF_ACT && hwdata[0] && !act_q;

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the bus pipeline and of the software registers.
  always_comb begin
    wr_d = accept && hwrite;
    rp_d = accept && !hwrite;
    a_d = accept ? haddr[TRC_AW-1:0] : a_q;
    if (accept && haddr[31:TRC_AW] != '0) begin
      wr_d = 1'b0;
      a_d = OFF_STAT + 8'h10;
    end
    mask_d = mask_q;
    act_d = act_q;
    share_d = share_q;
    rdata_d = rdata_q;
    if (wr_q) begin
      if (a_q < OFF_ACT) begin
        mask_d[a_q[4:2]] = hwdata[DW-1:0];
      end else if (a_q == OFF_ACT) begin
        act_d = hwdata[0];
      end else if (a_q == OFF_SHARE) begin
        share_d = hwdata[15:0];
      end
    end
    if (rp_q) begin
      rdata_d = '0;
      if (a_q < OFF_ACT) begin
        rdata_d[DW-1:0] = mask_q[a_q[4:2]];
      end else if (a_q == OFF_ACT) begin
        rdata_d[0] = act_q;
      end else if (a_q == OFF_SHARE) begin
        rdata_d[15:0] = share_q;
      end else if (a_q == OFF_STAT) begin
        rdata_d[STAT_RUN_BIT] = trace_running;
        rdata_d[STAT_DONE_BIT] = trace_done;
        rdata_d[STAT_ACT_BIT] = act_q;
      end else if (a_q == OFF_COUNT) begin
        rdata_d = cnt_q;
      end
    end
  end

  // Registers of the bus pipeline and of the software view.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rp_q <= 1'b0;
      a_q <= '0;
      rdata_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        mask_q[i] <= RST_MASK;
      end
      act_q <= 1'b0;
      // [RULE6] share resets to full
      share_q <= RST_SHARE;
    end else begin
      wr_q <= wr_d;
      rp_q <= rp_d;
      a_q <= a_d;
      rdata_q <= rdata_d;
      mask_q <= mask_d;
      act_q <= act_d;
      share_q <= share_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trace sequencer: shadows, capacity and sample count.
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cap_d = cap_q;
    cnt_d = cnt_q;
    if (start) begin
      // [RULE4] [RULE5] shadow load only here
      sh_d = mask_q;
      // [RULE7] capacity from share
      cap_d = 32'((32'(share_eff) * 32'(TOTAL_MEM)) / 32'(PCT_FULL));
      cnt_d = '0;
      st_d = TRC_RUN;
    end else begin
      case (st_q)
        TRC_RUN: begin
          if (push) begin
            cnt_d = cnt_q + 32'h00000001;
          end
          if (!act_q) begin
            st_d = TRC_IDLE;
          end else if (push && cnt_d >= cap_q) begin
            st_d = TRC_DONE;
          end
        end
        TRC_DONE: begin
          if (!act_q) begin
            st_d = TRC_IDLE;
          end
        end
        default: begin
          st_d = TRC_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= TRC_IDLE;
      cap_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        sh_q[i] <= RST_MASK;
      end
    end else begin
      st_q <= st_d;
      cap_q <= cap_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel masking with the captured masks; values above 16 act as 0.
  // [RULE1] [RULE2] bit isolation
  always_comb begin
    push_data = smp_data;
    for (int c = 0; c < NCH; c++) begin
      if (sh_q[c] != MASK_NORMAL && sh_q[c] <= MASK_MAX) begin
        push_data[c*DW +: DW] = '0;
        push_data[c*DW] = smp_data[c*DW + 32'(sh_q[c] - 16'h0001)];
      end
    end
  end

  // Samples are taken only while running and the FIFO has room.
  assign smp_ready = trace_running && fifo_rdy;
  assign push = smp_valid && smp_ready;

  // Record FIFO that carries masked samples to the memory writer.
  trcrec_fifo #(
    .W(NCH * DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .in_valid(push),
    .in_ready(fifo_rdy),
    .in_data(push_data),
    .out_valid(rec_valid),
    .out_ready(rec_ready),
    .out_data(rec_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the design's own behaviour.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_act_write;
    wr_q && a_q == OFF_ACT && hwdata[0];
  endsequence

  sequence s_read_two;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_mask_normal;
    push && sh_q[0] == MASK_NORMAL |-> push_data[DW-1:0] == smp_data[DW-1:0];
  endproperty
  a_mask_normal: assert property (p_mask_normal) // [RULE1]
    else $error("normal mask altered the word");

  property p_mask_bit;
    push && sh_q[1] == 16'h0001 |->
      push_data[2*DW-1:DW] == {15'h0000, smp_data[DW]};
  endproperty
  a_mask_bit: assert property (p_mask_bit) // [RULE1]
    else $error("mask 1 did not isolate bit 0");

  property p_input_one;
    push && sh_q[3] == 16'h0008 |->
      push_data[3*DW] == smp_data[3*DW+7];
  endproperty
  a_input_one: assert property (p_input_one) // [RULE2]
    else $error("mask 8 did not select bit 7");

  property p_start_runs;
    s_act_write ##0 !act_q |=> trace_running && cnt_q == '0;
  endproperty
  a_start_runs: assert property (p_start_runs) // [RULE3]
    else $error("activation did not start the trace");

  property p_capture;
    start |=> sh_q[3] == $past(mask_q[3]);
  endproperty
  a_capture: assert property (p_capture) // [RULE4]
    else $error("mask not captured at activation");

  property p_hold;
    act_q && !start |=> $stable(sh_q[5]) && $stable(cap_q);
  endproperty
  a_hold: assert property (p_hold) // [RULE5]
    else $error("settings changed during an active trace");

  property p_share_clamp;
    start && share_q == 16'h0000 |=>
      cap_q == 32'((32'(SHARE_MIN) * 32'(TOTAL_MEM)) / 32'(PCT_FULL));
  endproperty
  a_share_clamp: assert property (p_share_clamp) // [RULE6]
    else $error("share below one percent not clamped");

  property p_capacity;
    trace_running && push && cnt_q + 32'h00000001 >= cap_q && act_q
      |=> trace_done;
  endproperty
  a_capacity: assert property (p_capacity) // [RULE7]
    else $error("trace did not stop at capacity");

  property p_read_wait;
    accept && !hwrite |=> s_read_two;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read did not take one wait state");
endmodule : trcrec_ctrl
`default_nettype wire

// [design/trcrec_fifo.sv]
// Record FIFO with a registered head word and valid/ready on both sides.
`default_nettype none
module trcrec_fifo #(
  parameter int W = 128,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic hv_q, hv_d;
  logic [W-1:0] hd_q, hd_d;
  logic push, pop, load;

  ////////////////////////////////////////////////////////////////////////////
  // Storage is full when the memory holds DEPTH words besides the head.
  assign in_ready = (cnt_q != CW'(DEPTH));
  assign out_valid = hv_q;
  assign out_data = hd_q;
  assign push = in_valid && in_ready;
  assign pop = hv_q && out_ready;
  assign load = !hv_q || pop;

  // Next head, pointers and count; an empty store lets data bypass to head.
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    hv_d = hv_q && !pop;
    hd_d = hd_q;
    if (load && cnt_q != '0) begin
      hv_d = 1'b1;
      hd_d = mem_q[rd_q];
      rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_d = cnt_d - 1'b1;
    end
    if (push && load && cnt_q == '0) begin
      hv_d = 1'b1;
      hd_d = in_data;
    end else if (push) begin
      wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      cnt_d = cnt_d + 1'b1;
    end
  end

  // Control state registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      hv_q <= 1'b0;
      hd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      hv_q <= hv_d;
      hd_q <= hd_d;
    end
  end

  // Word store, written only when the word does not bypass to the head.
  always_ff @(posedge clk) begin
    if (push && !(load && cnt_q == '0)) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : trcrec_fifo
`default_nettype wire

// [shared/trcrec_pkg.sv]
// Trace recorder control constants: register map, reset values, fields.
`default_nettype none
package trcrec_pkg;
  localparam int TRC_AW = 8;
  localparam logic [7:0] OFF_MASK0 = 8'h00;
  localparam logic [7:0] OFF_ACT = 8'h20;
  localparam logic [7:0] OFF_SHARE = 8'h24;
  localparam logic [7:0] OFF_STAT = 8'h28;
  localparam logic [7:0] OFF_COUNT = 8'h2C;
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam logic [15:0] RST_SHARE = 16'h0064;
  localparam logic [15:0] MASK_NORMAL = 16'h0000;
  localparam logic [15:0] MASK_MAX = 16'h0010;
  localparam logic [15:0] SHARE_MIN = 16'h0001;
  localparam logic [15:0] SHARE_MAX = 16'h0064;
  localparam int PCT_FULL = 100;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ACT_BIT = 2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  typedef enum logic [1:0] {TRC_IDLE, TRC_RUN, TRC_DONE} trcrec_state_t;
endpackage : trcrec_pkg
`default_nettype wire

// [verification/tb_trace_recorder_control.sv]
// Self-checking bench for the trace recorder control block.
`default_nettype none
module tb_trace_recorder_control;
  import trcrec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TMEM = 200;
  localparam int CAP = TMEM * 5 / PCT_FULL;
  // Capacity when a share of 0 is clamped up to one percent.
  localparam int CAP_MIN = TMEM * 1 / PCT_FULL;
  // The FIFO holds eight stored words plus its head word.
  localparam int FIFO_FULL_WORDS = 9;
  localparam logic [127:0] PAT = 128'hA5C3_5A3C_F00F_0FF0_1234_EDCB_8001_7FFE;
  logic hclk, hresetn, hsel, hwrite, hresp, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic smp_valid, smp_ready, rec_valid, rec_ready;
  logic trace_running, trace_done;
  logic [127:0] smp_data, rec_data;
  logic [15:0] mtab [8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0008,
                            16'h0009, 16'h000A, 16'h0010, 16'h0011};
  logic [15:0] cur_m [8];
  int n_errors = 0;
  int cmp_count = 0;

  // Design under test with a short trace memory.
  trcrec_ctrl #(.TOTAL_MEM(TMEM)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data),
    .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data),
    .trace_running(trace_running), .trace_done(trace_done));

  // Clock of 50 ns period.
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task chk(input string what, input logic [127:0] exp,
           input logic [127:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Waits for hready high at a rising edge, under a bound.
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        n_errors++;
        stop_test();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  // One single AHB-Lite word transfer; read data lands in rd.
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : ahb

  task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000);
    chk(what, {96'h0, exp}, {96'h0, rd});
  endtask : rdchk

  // Expected record word from the settings captured at activation.
  function automatic logic [127:0] masked(input logic [127:0] d);
    logic [127:0] r;
    r = d;
    for (int c = 0; c < 8; c++) begin
      if (cur_m[c] != 16'h0000 && cur_m[c] <= MASK_MAX) begin
        r[16*c +: 16] = {15'h0000, d[16*c + int'(cur_m[c]) - 1]};
      end
    end
    return r;
  endfunction : masked

  // Offers one sample, waits for it, then takes the record word.
  task send_take(input logic [127:0] d);
    int n;
    n = 0;
    smp_valid <= 1'b1;
    smp_data <= d;
    @(posedge hclk);
    while (smp_ready !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    smp_valid <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      stop_test();
    end
    n = 0;
    while (rec_valid !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    if (n >= 50) begin
      n_errors++;
      stop_test();
    end
    chk("rec_data", masked(d), rec_data);
    rec_ready <= 1'b1;
    @(posedge hclk);
    rec_ready <= 1'b0;
  endtask : send_take

  task t_regs;
    for (int c = 0; c < 8; c++) begin
      rdchk("mask reset", OFF_MASK0 + 8'(4 * c), {16'h0, RST_MASK});
    end
    rdchk("act reset", OFF_ACT, 32'h00000000);
    rdchk("share reset", OFF_SHARE, {16'h0, RST_SHARE});
    ahb(1'b1, 8'h40, 32'h0000FFFF);
    rdchk("unmapped", 8'h40, 32'h00000000);
    ahb(1'b1, OFF_SHARE, 32'h00000025);
    rdchk("share rw", OFF_SHARE, 32'h00000025);
    ahb(1'b1, OFF_SHARE, {16'h0, SHARE_MAX});
  endtask : t_regs

  task t_mask;
    for (int c = 0; c < 8; c++) begin
      ahb(1'b1, OFF_MASK0 + 8'(4 * c), {16'h0, mtab[c]});
      cur_m[c] = mtab[c];
    end
    ahb(1'b1, OFF_ACT, 32'h00000001);
    rdchk("status run", OFF_STAT, 32'h00000005);
    send_take(PAT);
    send_take(~PAT);
  endtask : t_mask

  task t_hold;
    ahb(1'b1, OFF_MASK0, {16'h0, MASK_MAX});
    ahb(1'b1, OFF_ACT, 32'h00000001);
    send_take(PAT);
    ahb(1'b1, OFF_ACT, 32'h00000000);
    ahb(1'b1, OFF_ACT, 32'h00000001);
    cur_m[0] = MASK_MAX;
    send_take(PAT);
  endtask : t_hold

  task t_cap;
    int n;
    n = 0;
    ahb(1'b1, OFF_ACT, 32'h00000000);
    ahb(1'b1, OFF_SHARE, 32'h00000005);
    ahb(1'b1, OFF_ACT, 32'h00000001);
    smp_valid <= 1'b1;
    for (int i = 0; i < 80; i++) begin
      if (i == 40) begin
        chk("fill count", 128'(FIFO_FULL_WORDS), 128'(n));
        rec_ready <= 1'b1;
      end
      @(posedge hclk);
      if (smp_ready === 1'b1) begin
        n++;
        smp_data <= smp_data + 128'h1;
      end
    end
    chk("accepted", 128'(CAP), 128'(n));
    chk("trace_done", 128'h1, {127'h0, trace_done});
    chk("smp_ready", 128'h0, {127'h0, smp_ready});
    smp_valid <= 1'b0;
    rec_ready <= 1'b0;
    rdchk("status done", OFF_STAT, 32'h00000006);
    rdchk("count", OFF_COUNT, 32'(CAP));
    ahb(1'b1, OFF_ACT, 32'h00000000);
    rdchk("status idle", OFF_STAT, 32'h00000000);
    // A share of 0 is clamped to one percent, so two samples fill it.
    ahb(1'b1, OFF_SHARE, 32'h00000000);
    ahb(1'b1, OFF_ACT, 32'h00000001);
    send_take(PAT);
    send_take(~PAT);
    rdchk("clamp done", OFF_STAT, 32'h00000006);
    rdchk("clamp count", OFF_COUNT, 32'(CAP_MIN));
    ahb(1'b1, OFF_ACT, 32'h00000000);
  endtask : t_cap

  // Reset, outputs during reset, then the scenarios in turn.
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    smp_valid = 1'b0;
    smp_data = 128'h0;
    rec_ready = 1'b0;
    for (int c = 0; c < 8; c++) begin
      cur_m[c] = RST_MASK;
    end
    repeat (16) @(posedge hclk);
    chk("reset outs", 128'h10,
        {123'h0, hreadyout, hresp, smp_ready, rec_valid, trace_running});
    hresetn <= 1'b1;
    t_regs();
    t_mask();
    t_hold();
    t_cap();
    stop_test();
  end
endmodule : tb_trace_recorder_control
`default_nettype wire
